// ---- ebic_defines.vh ----
`ifndef EBIC_DEFINES_VH
`define EBIC_DEFINES_VH

// --------
// register byte offsets
// --------
`define EBIC_OFF_CTRL       12'h000
`define EBIC_OFF_STATUS     12'h004
`define EBIC_OFF_IDLECNT    12'h008

// --------
// control register fields
// --------
`define EBIC_BIT_XAREA      7
`define EBIC_BIT_RDWR       6
`define EBIC_BIT_BURST_EN   5
`define EBIC_BIT_BLEN       4
`define EBIC_BIT_BCNT       3
`define EBIC_CTRL_LO        3
`define EBIC_CTRL_RST       5'h1a

// --------
// status register fields
// --------
`define EBIC_BIT_BUSY       0
`define EBIC_BIT_BURSTING   1
`define EBIC_BIT_IDLED      2

// --------
// bus timing in states (one state is one aclk period)
// --------
`define EBIC_BASIC_STATES   4'h2
`define EBIC_BURST_SHORT    4'h1
`define EBIC_BURST_LONG     4'h2
`define EBIC_GRP_SHIFT_4W   2
`define EBIC_GRP_SHIFT_8W   3

// --------
// axi responses
// --------
`define EBIC_RESP_OKAY      2'b00
`define EBIC_RESP_SLVERR    2'b10

`endif

// ---- ebic_burst_ctl.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ebic_defines.vh"

module ebic_burst_ctl #(
    parameter ADDR_W = 16
) (
    input  wire              burst_en,     // area 0 runs as burst rom
    input  wire              len_sel,      // 0: 1 state, 1: 2 states
    input  wire              cnt_sel,      // 0: 4 words, 1: 8 words
    input  wire              is_read,      // new access is a read
    input  wire              is_area0,     // new access targets area 0
    input  wire [ADDR_W-1:0] addr,         // new access byte address
    input  wire              prev_valid,   // previous cycle was an area 0 read
    input  wire [ADDR_W-1:0] prev_addr,    // previous access byte address
    output wire              burst_hit,    // access continues a burst
    output wire [3:0]        cyc_states    // states the access cycle takes
);

    wire [ADDR_W-1:0] next_word_addr;
    wire [ADDR_W-1:0] grp_new;
    wire [ADDR_W-1:0] grp_prev;
    wire              same_group;

    assign next_word_addr = prev_addr + {{(ADDR_W-2){1'b0}}, 2'b10};

    // the word count limit is enforced by requiring the same aligned group
    assign grp_new  = cnt_sel ? (addr >> (`EBIC_GRP_SHIFT_8W + 1))
                              : (addr >> (`EBIC_GRP_SHIFT_4W + 1));
    assign grp_prev = cnt_sel ? (prev_addr >> (`EBIC_GRP_SHIFT_8W + 1))
                              : (prev_addr >> (`EBIC_GRP_SHIFT_4W + 1));
    assign same_group = (grp_new == grp_prev);

    // the first word always pays the full basic cycle
    assign burst_hit = burst_en && is_read && is_area0 && prev_valid
                       && same_group && (addr == next_word_addr);

    assign cyc_states = burst_hit ? (len_sel ? `EBIC_BURST_LONG : `EBIC_BURST_SHORT)
                                  : `EBIC_BASIC_STATES;

endmodule

`default_nettype wire

// ---- ebic_top.v ----
// Functional notes
// - idle state between reads to different areas
// - idle state between read and following write
// - area 0 burst rom mode, default off
// - burst cycle one or two states
// - burst limited to four or eight words
`timescale 1ns/1ns
`default_nettype none
`include "ebic_defines.vh"

module ebic_top #(
    parameter ADDR_W    = 16,
    parameter AREA_BITS = 3,
    parameter DATA_W    = 16
) (
    input  wire                  aclk,             // system clock
    input  wire                  aresetn,          // sync reset, active low
    input  wire [11:0]           awaddr,           // axi write address
    input  wire                  awvalid,          // axi write address valid
    output wire                  awready,          // axi write address ready
    input  wire [31:0]           wdata,            // axi write data
    input  wire [3:0]            wstrb,            // axi write strobes
    input  wire                  wvalid,           // axi write data valid
    output wire                  wready,           // axi write data ready
    output reg  [1:0]            bresp,            // axi write response
    output reg                   bvalid,           // axi write response valid
    input  wire                  bready,           // axi write response ready
    input  wire [11:0]           araddr,           // axi read address
    input  wire                  arvalid,          // axi read address valid
    output wire                  arready,          // axi read address ready
    output reg  [31:0]           rdata,            // axi read data
    output reg  [1:0]            rresp,            // axi read response
    output reg                   rvalid,           // axi read data valid
    input  wire                  rready,           // axi read data ready
    input  wire                  acc_valid,        // access request valid
    output wire                  acc_ready,        // access request taken
    input  wire                  acc_write,        // access is a write
    input  wire [ADDR_W-1:0]     acc_addr,         // access byte address
    input  wire [DATA_W-1:0]     acc_wdata,        // access write data
    output reg  [DATA_W-1:0]     acc_rdata,        // access read data
    output reg                   acc_rdata_valid,  // read data pulse
    output reg  [ADDR_W-1:0]     ext_addr,         // external address
    output reg  [(1<<AREA_BITS)-1:0] ext_cs_n,     // area selects, low active
    output reg                   ext_rd_n,         // read strobe, low active
    output reg                   ext_wr_n,         // write strobe, low active
    output reg  [DATA_W-1:0]     ext_data_out,     // data pin drive value
    output reg                   ext_data_oe,      // data pin drive enable
    input  wire [DATA_W-1:0]     ext_data_in       // data pin level
);

    // ---------------------------------------------------------------
    // bus cycle states
    // ---------------------------------------------------------------
    localparam [2:0] ST_READY  = 3'b001;
    localparam [2:0] ST_IDLE   = 3'b010;
    localparam [2:0] ST_ACCESS = 3'b100;
    localparam       NUM_AREAS = 1 << AREA_BITS;

    reg  [4:0]           ctrl;
    reg  [2:0]           state;
    reg  [3:0]           cnt;
    reg                  cur_write;
    reg  [ADDR_W-1:0]    cur_addr;
    reg  [DATA_W-1:0]    cur_wdata;
    reg                  cur_burst;
    reg                  last_valid;
    reg                  last_read;
    reg  [AREA_BITS-1:0] last_area;
    reg  [ADDR_W-1:0]    last_addr;
    reg                  last_idled;
    reg  [15:0]          idle_cnt;
    reg  [DATA_W-1:0]    din_meta;
    reg  [DATA_W-1:0]    din_sync;
    reg  [1:0]           rd_pend;

    reg                  aw_held;
    reg  [11:0]          aw_addr_q;
    reg                  w_held;
    reg  [31:0]          w_data_q;
    reg  [3:0]           w_strb_q;

    wire                 ctl_xarea;
    wire                 ctl_rdwr;
    wire                 ctl_burst_en;
    wire                 ctl_blen;
    wire                 ctl_bcnt;
    wire [AREA_BITS-1:0] new_area;
    wire                 need_idle;
    wire                 take;
    wire                 burst_hit;
    wire [3:0]           cyc_states;
    wire [3:0]           next_cnt;
    wire                 do_write;

    assign ctl_xarea    = ctrl[`EBIC_BIT_XAREA - `EBIC_CTRL_LO];
    assign ctl_rdwr     = ctrl[`EBIC_BIT_RDWR - `EBIC_CTRL_LO];
    assign ctl_burst_en = ctrl[`EBIC_BIT_BURST_EN - `EBIC_CTRL_LO];
    assign ctl_blen     = ctrl[`EBIC_BIT_BLEN - `EBIC_CTRL_LO];
    assign ctl_bcnt     = ctrl[`EBIC_BIT_BCNT - `EBIC_CTRL_LO];

    // ---------------------------------------------------------------
    // axi4-lite write channel
    // ---------------------------------------------------------------
    // address and data are caught separately so either may come first
    assign awready  = !aw_held && !bvalid;
    assign wready   = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held   <= 1'b0;
            aw_addr_q <= 12'h000;
            w_held    <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `EBIC_RESP_OKAY;
            ctrl      <= `EBIC_CTRL_RST;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held   <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                if (aw_addr_q[11:2] == `EBIC_OFF_CTRL >> 2)
                begin
                    bresp <= `EBIC_RESP_OKAY;
                    if (w_strb_q[0])
                        ctrl <= w_data_q[7:3];
                end
                else if (aw_addr_q[11:2] == `EBIC_OFF_STATUS >> 2)
                    bresp <= `EBIC_RESP_OKAY;
                else if (aw_addr_q[11:2] == `EBIC_OFF_IDLECNT >> 2)
                    bresp <= `EBIC_RESP_OKAY;
                else
                    bresp <= `EBIC_RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // --------
    // axi4-lite read channel
    // --------
    assign arready = !rvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `EBIC_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp  <= `EBIC_RESP_OKAY;
            if (araddr[11:2] == `EBIC_OFF_CTRL >> 2)
                rdata <= {24'h000000, ctrl, 3'h0};
            else if (araddr[11:2] == `EBIC_OFF_STATUS >> 2)
                rdata <= {29'h0000_0000, last_idled, cur_burst, !state[0]};
            else if (araddr[11:2] == `EBIC_OFF_IDLECNT >> 2)
                rdata <= {16'h0000, idle_cnt};
            else
            begin
                rdata <= 32'h0000_0000;
                rresp <= `EBIC_RESP_SLVERR;
            end
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    // --------
    // data pin synchroniser
    // --------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            din_meta <= {DATA_W{1'b0}};
            din_sync <= {DATA_W{1'b0}};
        end
        else
        begin
            din_meta <= ext_data_in;
            din_sync <= din_meta;
        end
    end

    // --------
    // idle insertion decision
    // --------
    assign acc_ready = state[0];
    assign take      = acc_ready && acc_valid;
    assign new_area  = acc_addr[ADDR_W-1 -: AREA_BITS];

    // last_valid only survives when accesses follow back to back
    assign need_idle = last_valid && last_read &&
                       ((acc_write && ctl_rdwr) ||
                        (!acc_write && ctl_xarea && new_area != last_area));

    ebic_burst_ctl #(
        .ADDR_W     (ADDR_W)
    ) u_burst (
        .burst_en   (ctl_burst_en),
        .len_sel    (ctl_blen),
        .cnt_sel    (ctl_bcnt),
        .is_read    (!acc_write),
        .is_area0   (new_area == {AREA_BITS{1'b0}}),
        .addr       (acc_addr),
        .prev_valid (last_valid && last_read && last_area == {AREA_BITS{1'b0}}),
        .prev_addr  (last_addr),
        .burst_hit  (burst_hit),
        .cyc_states (cyc_states)
    );

    assign next_cnt = cyc_states - 4'h1;

    // ---------------------------------------------------------------
    // bus cycle sequencer
    // ---------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state           <= ST_READY;
            cnt             <= 4'h0;
            cur_write       <= 1'b0;
            cur_addr        <= {ADDR_W{1'b0}};
            cur_wdata       <= {DATA_W{1'b0}};
            cur_burst       <= 1'b0;
            last_valid      <= 1'b0;
            last_read       <= 1'b0;
            last_area       <= {AREA_BITS{1'b0}};
            last_addr       <= {ADDR_W{1'b0}};
            last_idled      <= 1'b0;
            idle_cnt        <= 16'h0000;
            acc_rdata       <= {DATA_W{1'b0}};
            acc_rdata_valid <= 1'b0;
            rd_pend         <= 2'b00;
        end
        else
        begin
            // data lags the pins by two sync stages
            rd_pend         <= {rd_pend[0], 1'b0};
            acc_rdata_valid <= rd_pend[1];
            if (rd_pend[1])
                acc_rdata <= din_sync;
            case (state)
                ST_READY:
                begin
                    if (take)
                    begin
                        cur_write  <= acc_write;
                        cur_addr   <= acc_addr;
                        cur_wdata  <= acc_wdata;
                        cur_burst  <= burst_hit;
                        cnt        <= next_cnt;
                        last_idled <= need_idle;
                        if (need_idle)
                        begin
                            state <= ST_IDLE;
                            if (idle_cnt != 16'hffff)
                                idle_cnt <= idle_cnt + 16'h0001;
                        end
                        else
                            state <= ST_ACCESS;
                    end
                    else
                        last_valid <= 1'b0;
                end
                ST_IDLE:
                    state <= ST_ACCESS;
                ST_ACCESS:
                begin
                    if (cnt == 4'h0)
                    begin
                        state      <= ST_READY;
                        last_valid <= 1'b1;
                        last_read  <= !cur_write;
                        last_area  <= cur_addr[ADDR_W-1 -: AREA_BITS];
                        last_addr  <= cur_addr;
                        rd_pend    <= {rd_pend[0], !cur_write};
                    end
                    else
                        cnt <= cnt - 4'h1;
                end
                default:
                    state <= ST_READY;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // external pins
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_AREAS; gi = gi + 1)
        begin : g_cs
            always @(posedge aclk)
            begin
                if (!aresetn)
                    ext_cs_n[gi] <= 1'b1;
                else if (state == ST_READY && take && !need_idle)
                    ext_cs_n[gi] <= (new_area != gi);
                else if (state == ST_IDLE)
                    ext_cs_n[gi] <= (cur_addr[ADDR_W-1 -: AREA_BITS] != gi);
                else if (state == ST_ACCESS && cnt == 4'h0)
                    ext_cs_n[gi] <= 1'b1;
            end
        end
    endgenerate

    // strobes assert one state late after an inserted idle state
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_addr     <= {ADDR_W{1'b0}};
            ext_rd_n     <= 1'b1;
            ext_wr_n     <= 1'b1;
            ext_data_out <= {DATA_W{1'b0}};
            ext_data_oe  <= 1'b0;
        end
        else if (state == ST_READY && take && !need_idle)
        begin
            ext_addr     <= acc_addr;
            ext_rd_n     <= acc_write;
            ext_wr_n     <= !acc_write;
            ext_data_out <= acc_wdata;
            ext_data_oe  <= acc_write;
        end
        else if (state == ST_IDLE)
        begin
            ext_addr     <= cur_addr;
            ext_rd_n     <= cur_write;
            ext_wr_n     <= !cur_write;
            ext_data_out <= cur_wdata;
            ext_data_oe  <= cur_write;
        end
        else if (state == ST_ACCESS && cnt == 4'h0)
        begin
            ext_rd_n    <= 1'b1;
            ext_wr_n    <= 1'b1;
            ext_data_oe <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- ebic_chk_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ebic_defines.vh"
module ebic_chk #(
    parameter ADDR_W    = 16,
    parameter AREA_BITS = 3
) (
    input wire logic              aclk,            // clock
    input wire logic              aresetn,         // reset, low active
    input wire logic [11:0]       awaddr,          // write address
    input wire logic              awvalid,         // write address valid
    input wire logic              awready,         // write address ready
    input wire logic [31:0]       wdata,           // write data
    input wire logic [3:0]        wstrb,           // write strobes
    input wire logic              wvalid,          // write data valid
    input wire logic              wready,          // write data ready
    input wire logic              acc_valid,       // access valid
    input wire logic              acc_ready,       // access taken
    input wire logic              acc_write,       // access is a write
    input wire logic [ADDR_W-1:0] acc_addr,        // access address
    input wire logic              acc_rdata_valid, // read done pulse
    input wire logic [ADDR_W-1:0] ext_addr,        // bus address
    input wire logic              ext_rd_n,        // read strobe
    input wire logic              ext_wr_n         // write strobe
);
    // --------
    // helper state
    // --------
    // shadow assumes address and data are taken together, as the bench does
    logic [4:0]           sh;
    logic [ADDR_W-1:0]    cur_a;
    logic [ADDR_W-1:0]    prv_a;
    logic [AREA_BITS-1:0] cur_ar;
    logic                 take;
    logic                 rd_q;
    assign cur_ar = cur_a[ADDR_W-1 -: AREA_BITS];
    assign take   = acc_valid && acc_ready && ext_rd_n && !rd_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sh <= `EBIC_CTRL_RST;
        else if (awvalid && awready && wvalid && wready && awaddr == `EBIC_OFF_CTRL && wstrb[0])
            sh <= wdata[7:3];
    end
    always_ff @(posedge aclk)
    begin
        rd_q <= ext_rd_n;
        if ($fell(ext_rd_n))
        begin
            cur_a <= ext_addr;
            prv_a <= cur_a;
        end
    end
    // --------
    // properties
    // --------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rd_two;
        $fell(ext_rd_n) && (sh[1] || !sh[2]) |-> ##1 !ext_rd_n ##1 ext_rd_n;
    endproperty
    a_rd_two: assert property (p_rd_two) else $error("read cycle not two states");
    property p_rd_short;
        $fell(ext_rd_n) ##1 ext_rd_n |-> sh[2] && !sh[1] && cur_ar == 0
            && cur_a[ADDR_W-1:1] == prv_a[ADDR_W-1:1] + 1'b1
            && (sh[0] ? cur_a[ADDR_W-1:4] == prv_a[ADDR_W-1:4]
                      : cur_a[ADDR_W-1:3] == prv_a[ADDR_W-1:3]);
    endproperty
    a_rd_short: assert property (p_rd_short) else $error("bad short burst read");
    property p_rd_end;
        $rose(ext_rd_n) |-> ##2 acc_rdata_valid;
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("read end without data");
    property p_wr_len;
        $fell(ext_wr_n) |-> ##1 !ext_wr_n ##1 ext_wr_n;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write cycle length");
    property p_x_on;
        take && !acc_write && sh[4] && acc_addr[ADDR_W-1 -: AREA_BITS] != cur_ar
            |-> ##1 ext_rd_n ##1 !ext_rd_n;
    endproperty
    a_x_on: assert property (p_x_on) else $error("no idle across areas");
    property p_x_off;
        take && !acc_write && (!sh[4] || acc_addr[ADDR_W-1 -: AREA_BITS] == cur_ar)
            |-> ##1 !ext_rd_n;
    endproperty
    a_x_off: assert property (p_x_off) else $error("unwanted read idle");
    property p_rw_on;
        take && acc_write && sh[3] |-> ##1 ext_wr_n ##1 !ext_wr_n;
    endproperty
    a_rw_on: assert property (p_rw_on) else $error("no idle before write");
    property p_rw_off;
        take && acc_write && !sh[3] |-> ##1 !ext_wr_n;
    endproperty
    a_rw_off: assert property (p_rw_off) else $error("unwanted write idle");
endmodule
bind ebic_top ebic_chk #(.ADDR_W(ADDR_W), .AREA_BITS(AREA_BITS)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .acc_valid(acc_valid),
    .acc_ready(acc_ready), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_rdata_valid(acc_rdata_valid), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n));
`default_nettype wire

// ---- ebic_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ebic_mem_model (
    input  wire logic        aclk,         // clock
    input  wire logic [15:0] ext_addr,     // address
    input  wire logic [7:0]  ext_cs_n,     // area selects
    input  wire logic        ext_rd_n,     // read strobe
    input  wire logic        ext_wr_n,     // write strobe
    input  wire logic [15:0] ext_data_out, // data from device
    input  wire logic        ext_data_oe,  // device drives data
    output logic      [15:0] ext_data_in   // data to device
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    logic        sel;
    assign sel = ~&ext_cs_n;
    initial
    begin
        foreach (mem[i]) mem[i] = 16'ha500 ^ 16'(i);
    end
    always @(posedge aclk)
    begin
        last <= ext_data_in;
        if (sel && !ext_wr_n && ext_data_oe)
            mem[ext_addr[8:1]] <= ext_data_out;
    end
    // released lines toggle so stale data never looks valid
    assign ext_data_in = (sel && !ext_rd_n) ? mem[ext_addr[8:1]] : ~last;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ebic_defines.vh"
module tb_top;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, acc_ready, acc_rdata_valid;
    logic [1:0] bresp, rresp;
    logic acc_valid = 1'h0, acc_write = 1'h0, ext_rd_n, ext_wr_n, ext_data_oe;
    logic [15:0] acc_addr = 16'h0, acc_wdata = 16'h0, acc_rdata, ext_addr;
    logic [15:0] ext_data_out, ext_data_in, emem [0:255];
    logic [7:0] ext_cs_n;
    logic [32:0] sq [$];
    logic [15:0] rq [$];
    int num_errors = 0, num_checks = 0;
    always #4 aclk = ~aclk;
    ebic_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_rdata_valid(acc_rdata_valid), .ext_addr(ext_addr), .ext_cs_n(ext_cs_n),
        .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_data_out(ext_data_out),
        .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in));
    ebic_mem_model u_mem (.aclk(aclk), .ext_addr(ext_addr), .ext_cs_n(ext_cs_n),
        .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_data_out(ext_data_out),
        .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in));
    // --------
    // checking and bus tasks
    // --------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do
        begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_ok)
                awvalid <= 1'h0;
            if (w_ok)
                wvalid <= 1'h0;
        end
        while (b_ok !== 1'h1);
        chk(r, er);
    endtask
    task axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_ok, r_ok;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'h1;
        do
        begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_ok)
                arvalid <= 1'h0;
        end
        while (r_ok !== 1'h1);
        chk(d, ed);
        chk(r, er);
    endtask
    // edges from the previous take (or call) to the next ready edge
    task wait_rdy(output int cyc);
        logic rdy;
        cyc = 0;
        do
        begin
            @(negedge aclk);
            rdy = acc_ready;
            @(posedge aclk);
            cyc++;
        end
        while (rdy !== 1'h1);
    endtask
    always @(negedge aclk)
        if (acc_rdata_valid)
            chk(acc_rdata, rq.pop_front());
    // --------
    // back-to-back access sequence under one control setting
    // --------
    task run_seq(input logic [7:0] c);
        int cyc, cost;
        logic hit, idle;
        logic [32:0] p, s;
        axw(`EBIC_OFF_CTRL, {24'h0, c}, 4'h1, `EBIC_RESP_OKAY);
        p = 33'h1_0000_0000;
        cost = 0;
        foreach (sq[i])
        begin
            s = sq[i];
            acc_valid <= 1'h1;
            acc_write <= s[32];
            acc_addr <= s[31:16];
            acc_wdata <= s[15:0];
            if (s[32])
                emem[s[24:17]] = s[15:0];
            else
                rq.push_back(emem[s[24:17]]);
            wait_rdy(cyc);
            if (i > 0) chk(cyc, cost);
            hit = c[5] && !s[32] && !p[32] && s[31:29] == 3'h0 && p[31:29] == 3'h0
                && s[31:16] == p[31:16] + 16'h2
                && (c[3] ? s[31:20] == p[31:20] : s[31:19] == p[31:19]);
            idle = !p[32] && (s[32] ? c[6] : c[7] && s[31:29] != p[31:29]);
            cost = (hit && !c[4] ? 1 : 2) + idle + 1;
            p = s;
        end
        acc_valid <= 1'h0;
        wait_rdy(cyc);
        chk(cyc, cost);
    endtask
    // --------
    // main sequence
    // --------
    initial
    begin
        foreach (emem[i]) emem[i] = 16'ha500 ^ 16'(i);
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        axr(`EBIC_OFF_CTRL, 32'h0000_00d0, `EBIC_RESP_OKAY);
        axw(12'h00c, 32'h0000_00ff, 4'hf, `EBIC_RESP_SLVERR);
        axr(12'h00c, 32'h0, `EBIC_RESP_SLVERR);
        axw(`EBIC_OFF_CTRL, 32'h0, 4'h0, `EBIC_RESP_OKAY);
        axr(`EBIC_OFF_CTRL, 32'h0000_00d0, `EBIC_RESP_OKAY);
        axw(`EBIC_OFF_CTRL, 32'hffff_ff07, 4'hf, `EBIC_RESP_OKAY);
        axr(`EBIC_OFF_CTRL, 32'h0, `EBIC_RESP_OKAY);
        sq = '{33'h1_2010_1234, 33'h0_2010_0000, 33'h0_4000_0000, 33'h1_4002_5678,
               33'h0_0000_0000, 33'h0_0002_0000};
        run_seq(8'hd0);
        run_seq(8'h40);
        run_seq(8'h80);
        run_seq(8'h00);
        sq = '{33'h0_0000_0000, 33'h0_0002_0000, 33'h0_0004_0000, 33'h0_0006_0000,
               33'h0_0008_0000, 33'h0_000a_0000, 33'h0_000c_0000, 33'h0_000e_0000,
               33'h0_0012_0000, 33'h0_2000_0000, 33'h0_2002_0000};
        run_seq(8'h20);
        run_seq(8'h30);
        run_seq(8'h28);
        run_seq(8'h38);
        repeat (3) @(posedge aclk);
        chk(rq.size(), 0);
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
